/* common/lcd_timing_map.svh */
// register offsets, field positions, codes and reset values of the lcd timing block
`ifndef LCD_TIMING_MAP_SVH
`define LCD_TIMING_MAP_SVH
`define ADDR_MAIN_CTRL 32'h4A000000
`define ADDR_STAT_POL 32'h4A000004
`define ADDR_VERT_TIM 32'h4A000008
`define ADDR_HORIZ_TIM 32'h4A00000C
`define ADDR_PANEL_SIZE 32'h4A000010
`define ADDR_OVL_CTRL 32'h4A000014
`define ADDR_OVL_TL 32'h4A000018
`define ADDR_OVL_BR 32'h4A00001C
`define PAL_PAGE 22'h128001
`define RESET_VALUE 32'h00000000
`define MASK_MAIN_CTRL 32'h000FF03E
`define MASK_STAT_POL 32'h000006EF
`define MASK_TIM 32'h00FFFFFF
`define MASK_SIZE 32'h003FFFFF
`define MASK_OVL_CTRL 32'h000003FF
`define MASK_ALL 32'hFFFFFFFF
`define F_FRAME_END_EN 0
`define F_NOW_EN 1
`define F_DEPTH 5:2
`define F_CLK_DIVIDED 12
`define F_CLK_DIV 18:13
`define F_DIV_EN 19
`define F_PAL_FMT 10:9
`define F_EDGE_SEL 7
`define F_LSYNC_INV 6
`define F_FSYNC_INV 5
`define F_DV_INV 3
`define F_BIT_SWAP 2
`define F_BYTE_SWAP 1
`define F_HALF_SWAP 0
`define F_BACK 23:16
`define F_FRONT 15:8
`define F_SYNC 7:0
`define F_HIGH 21:11
`define F_LOW 10:0
`define F_OVL_EN 9
`define F_OVL_PIX 8
`define F_OVL_ALPHA 7:0
`define DEPTH_1 4'h0
`define DEPTH_2 4'h1
`define DEPTH_4 4'h2
`define DEPTH_8PAL 4'h3
`define DEPTH_332 4'h4
`define DEPTH_565 4'h5
`define DEPTH_5551 4'h6
`define DEPTH_18 4'h7
`define PAL_666 2'h1
`define PAL_565 2'h2
`define PAL_5551 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* common/lcd_timing_pkg.sv */
// types shared by the lcd timing block and its surroundings
package lcd_timing_pkg;
    typedef enum logic [1:0] {PH_SYNC, PH_BACK, PH_ACTIVE, PH_FRONT} phase_e;
    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } axi_req_s;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;
    typedef struct packed {
        logic valid;
        logic [31:0] bg_word;
        logic [31:0] ov_word;
    } fetch_s;
    typedef struct packed {
        logic pixel_clock;
        logic line_sync;
        logic frame_sync;
        logic data_valid;
        logic [23:0] rgb;
    } panel_s;
endpackage

/* src/lcd_timing_overlay_control.sv */
// lcd timing generator with overlay blending and an axi4-lite register file
`timescale 1ns/1ps
`include "lcd_timing_map.svh"

// Notes on behaviour
// - background depth from 4-bit code, top-bit reserved
// - immediate enable starts output at once; stops it at once unless frame-end run is on
// - frame-end enable applied at frame end, or at once while stopped
// - frame-end bit reads one until frame finishes
// - line counter counts 0 to panel height
// - vertical and horizontal phase reported as status
// - palette entries decoded by 2-bit format
// - edge select picks panel sampling clock edge
// - each sync and valid output individually invertible
// - bit, byte, halfword swaps on fetched background word
// - back-porch lines follow frame sync
// - front-porch lines end each frame
// - frame sync width counted in lines
// - horizontal back porch before active pixels
// - horizontal front porch after active pixels
// - line sync width counted in pixel clocks
// - panel height and width from size register
// - overlay shown only when enabled; blend mode
// - alpha from register or pixel top byte
// - colour keying bypasses alpha blending
// - overlay window between two corner coordinates
// - pixel clock is bus clock over 2(n+1)
module lcd_timing_overlay_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire lcd_timing_pkg::axi_req_s axi_req,
    output lcd_timing_pkg::axi_rsp_s axi_rsp,
    input wire lcd_timing_pkg::fetch_s fetch,
    output logic fetch_ready,
    input wire logic color_key_en,
    output lcd_timing_pkg::panel_s panel
);
    import lcd_timing_pkg::*;

    logic rst_meta_q, rst_sync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    function automatic logic [23:0] fmt666(input logic [17:0] w);
        return {w[17:12], 2'h0, w[11:6], 2'h0, w[5:0], 2'h0};
    endfunction

    function automatic logic [23:0] fmt565(input logic [15:0] w);
        return {w[15:11], 3'h0, w[10:5], 2'h0, w[4:0], 3'h0};
    endfunction

    // intensity bit feeds the bit just below the five colour bits of every channel
    function automatic logic [23:0] fmt5551(input logic [15:0] w);
        return {w[15:11], w[0], 2'h0, w[10:6], w[0], 2'h0, w[5:1], w[0], 2'h0};
    endfunction

    function automatic logic [7:0] blend8(input logic [7:0] a, input logic [7:0] f,
                                          input logic [7:0] b);
        logic [15:0] s;
        s = 16'(f * a) + 16'(b * (8'hFF - a));
        return s[15:8];
    endfunction

    // register file
    logic [31:0] main_q, pol_q, vt_q, ht_q, ps_q, oc_q, tl_q, br_q;
    logic fe_pend_q;
    logic [31:0] pal_mem [256];

    logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
    logic [31:0] awaddr_q, wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rd_data;
    logic rd_ok;

    wire aw_rdy = ce & ~aw_got_q & ~bvalid_q;
    wire w_rdy = ce & ~w_got_q & ~bvalid_q;
    wire ar_rdy = ce & ~rvalid_q;
    wire aw_hs = axi_req.awvalid & aw_rdy;
    wire w_hs = axi_req.wvalid & w_rdy;
    wire ar_hs = axi_req.arvalid & ar_rdy;
    wire wr_fire = ce & aw_got_q & w_got_q & ~bvalid_q;

    wire sel_main = awaddr_q == `ADDR_MAIN_CTRL;
    wire sel_pol = awaddr_q == `ADDR_STAT_POL;
    wire sel_vt = awaddr_q == `ADDR_VERT_TIM;
    wire sel_ht = awaddr_q == `ADDR_HORIZ_TIM;
    wire sel_ps = awaddr_q == `ADDR_PANEL_SIZE;
    wire sel_oc = awaddr_q == `ADDR_OVL_CTRL;
    wire sel_tl = awaddr_q == `ADDR_OVL_TL;
    wire sel_br = awaddr_q == `ADDR_OVL_BR;
    wire sel_pal = awaddr_q[31:10] == `PAL_PAGE;
    wire wr_hit = sel_main | sel_pol | sel_vt | sel_ht | sel_ps | sel_oc | sel_tl | sel_br
                  | sel_pal;
    wire [7:0] wr_idx = awaddr_q[9:2];
    wire [7:0] rd_idx = axi_req.araddr[9:2];

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            awaddr_q <= 32'h00000000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (ce) begin
            if (aw_hs) begin
                aw_got_q <= 1'b1;
                awaddr_q <= axi_req.awaddr;
            end
            if (w_hs) begin
                w_got_q <= 1'b1;
                wdata_q <= axi_req.wdata;
                wstrb_q <= axi_req.wstrb;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_q && axi_req.bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            main_q <= `RESET_VALUE;
            pol_q <= `RESET_VALUE;
            vt_q <= `RESET_VALUE;
            ht_q <= `RESET_VALUE;
            ps_q <= `RESET_VALUE;
            oc_q <= `RESET_VALUE;
            tl_q <= `RESET_VALUE;
            br_q <= `RESET_VALUE;
            fe_pend_q <= 1'b0;
        end else if (wr_fire) begin
            if (sel_main) main_q <= merge(main_q, wdata_q, wstrb_q, `MASK_MAIN_CTRL);
            if (sel_main && wstrb_q[0]) fe_pend_q <= wdata_q[`F_FRAME_END_EN];
            if (sel_pol) pol_q <= merge(pol_q, wdata_q, wstrb_q, `MASK_STAT_POL);
            if (sel_vt) vt_q <= merge(vt_q, wdata_q, wstrb_q, `MASK_TIM);
            if (sel_ht) ht_q <= merge(ht_q, wdata_q, wstrb_q, `MASK_TIM);
            if (sel_ps) ps_q <= merge(ps_q, wdata_q, wstrb_q, `MASK_SIZE);
            if (sel_oc) oc_q <= merge(oc_q, wdata_q, wstrb_q, `MASK_OVL_CTRL);
            if (sel_tl) tl_q <= merge(tl_q, wdata_q, wstrb_q, `MASK_SIZE);
            if (sel_br) br_q <= merge(br_q, wdata_q, wstrb_q, `MASK_SIZE);
        end
    end

    // palette has no reset: it is a memory and software loads it before use
    always_ff @(posedge clk) begin
        if (wr_fire && sel_pal) begin
            pal_mem[wr_idx] <= merge(pal_mem[wr_idx], wdata_q, wstrb_q, `MASK_ALL);
        end
    end

    // video enable and timing state
    logic now_q, run_q;
    logic div_run, pclk_q;
    logic [5:0] div_q;
    phase_e hph_q, vph_q;
    logic [10:0] hcnt_q, vcnt_q;

    assign now_q = main_q[`F_NOW_EN];
    wire running = now_q | run_q;
    wire fe_read = fe_pend_q | run_q;

    wire [10:0] line_status = (vph_q == PH_ACTIVE) ? vcnt_q : 11'h000;
    wire [31:0] stat_word = {6'h00, line_status, vph_q, hph_q, 11'h000} | pol_q;

    always_comb begin
        rd_data = 32'h00000000;
        rd_ok = 1'b1;
        case (axi_req.araddr)
            `ADDR_MAIN_CTRL: rd_data = main_q | {31'h00000000, fe_read};
            `ADDR_STAT_POL: rd_data = stat_word;
            `ADDR_VERT_TIM: rd_data = vt_q;
            `ADDR_HORIZ_TIM: rd_data = ht_q;
            `ADDR_PANEL_SIZE: rd_data = ps_q;
            `ADDR_OVL_CTRL: rd_data = oc_q;
            `ADDR_OVL_TL: rd_data = tl_q;
            `ADDR_OVL_BR: rd_data = br_q;
            default: begin
                if (axi_req.araddr[31:10] == `PAL_PAGE) begin
                    rd_data = pal_mem[rd_idx];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `RESP_OKAY;
        end else if (ce) begin
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_data;
                rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rvalid_q && axi_req.rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign axi_rsp.awready = aw_rdy;
    assign axi_rsp.wready = w_rdy;
    assign axi_rsp.bvalid = bvalid_q;
    assign axi_rsp.bresp = bresp_q;
    assign axi_rsp.arready = ar_rdy;
    assign axi_rsp.rvalid = rvalid_q;
    assign axi_rsp.rdata = rdata_q;
    assign axi_rsp.rresp = rresp_q;

    // pixel clock divider; direct mode still divides by two, since the
    // bus clock itself cannot leave the block through a flip-flop
    wire div_mode = main_q[`F_CLK_DIVIDED];
    wire [5:0] div_val = div_mode ? main_q[`F_CLK_DIV] : 6'h00;
    assign div_run = running & (~div_mode | main_q[`F_DIV_EN]);
    wire div_wrap = div_run & (div_q == div_val);
    wire tick = ce & div_wrap & ~pclk_q;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div_q <= 6'h00;
            pclk_q <= 1'b0;
        end else if (ce) begin
            if (!running) begin
                div_q <= 6'h00;
                pclk_q <= 1'b0;
            end else if (div_run) begin
                div_q <= div_wrap ? 6'h00 : div_q + 6'h01;
                if (div_wrap) pclk_q <= ~pclk_q;
            end
        end
    end

    // each phase lasts its programmed value plus one unit
    function automatic logic [10:0] limit(input phase_e p, input logic [31:0] tim,
                                          input logic [10:0] size);
        logic [10:0] r;
        r = 11'h000;
        unique case (p)
            PH_SYNC: r = {3'h0, tim[`F_SYNC]};
            PH_BACK: r = {3'h0, tim[`F_BACK]};
            PH_ACTIVE: r = size;
            PH_FRONT: r = {3'h0, tim[`F_FRONT]};
        endcase
        return r;
    endfunction

    wire [10:0] hlim = limit(hph_q, ht_q, ps_q[`F_LOW]);
    wire [10:0] vlim = limit(vph_q, vt_q, ps_q[`F_HIGH]);
    wire h_last = hcnt_q == hlim;
    wire v_last = vcnt_q == vlim;
    wire line_end = tick & h_last & (hph_q == PH_FRONT);
    wire frame_end = line_end & v_last & (vph_q == PH_FRONT);
    wire in_active = (hph_q == PH_ACTIVE) & (vph_q == PH_ACTIVE);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hph_q <= PH_SYNC;
            vph_q <= PH_SYNC;
            hcnt_q <= 11'h000;
            vcnt_q <= 11'h000;
        end else if (ce && !running) begin
            hph_q <= PH_SYNC;
            vph_q <= PH_SYNC;
            hcnt_q <= 11'h000;
            vcnt_q <= 11'h000;
        end else if (tick) begin
            hcnt_q <= h_last ? 11'h000 : hcnt_q + 11'h001;
            if (h_last) hph_q <= phase_e'(2'(hph_q + 2'h1));
            if (line_end) begin
                vcnt_q <= v_last ? 11'h000 : vcnt_q + 11'h001;
                if (v_last) vph_q <= phase_e'(2'(vph_q + 2'h1));
            end
        end
    end

    // a stopped controller takes the pending frame-end value at once
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            run_q <= 1'b0;
        end else if (ce && (!running || frame_end)) begin
            run_q <= fe_pend_q;
        end
    end

    // pixel path
    assign fetch_ready = tick & in_active;
    wire take = fetch_ready & fetch.valid;

    wire [31:0] w0 = fetch.bg_word;
    wire [31:0] sw_h = pol_q[`F_HALF_SWAP] ? {w0[15:0], w0[31:16]} : w0;
    wire [31:0] sw_b = pol_q[`F_BYTE_SWAP] ?
                       {sw_h[23:16], sw_h[31:24], sw_h[7:0], sw_h[15:8]} : sw_h;
    wire [31:0] bw = pol_q[`F_BIT_SWAP] ? {<<{sw_b}} : sw_b;

    wire [3:0] depth = main_q[`F_DEPTH];
    logic [7:0] pal_idx;
    logic [23:0] bg_rgb;
    wire [31:0] pal_entry = pal_mem[pal_idx];
    logic [23:0] pal_rgb;

    always_comb begin
        unique case (pol_q[`F_PAL_FMT])
            `PAL_666: pal_rgb = fmt666(pal_entry[17:0]);
            `PAL_565: pal_rgb = fmt565(pal_entry[15:0]);
            `PAL_5551: pal_rgb = fmt5551(pal_entry[15:0]);
            default: pal_rgb = 24'h000000;
        endcase
    end

    always_comb begin
        pal_idx = bw[7:0];
        bg_rgb = pal_rgb;
        unique case (depth)
            `DEPTH_1: pal_idx = {7'h00, bw[0]};
            `DEPTH_2: pal_idx = {6'h00, bw[1:0]};
            `DEPTH_4: pal_idx = {4'h0, bw[3:0]};
            `DEPTH_8PAL: pal_idx = bw[7:0];
            `DEPTH_332: bg_rgb = {bw[7:5], 5'h00, bw[4:2], 5'h00, bw[1:0], 6'h00};
            `DEPTH_565: bg_rgb = fmt565(bw[15:0]);
            `DEPTH_5551: bg_rgb = fmt5551(bw[15:0]);
            `DEPTH_18: bg_rgb = fmt666(bw[17:0]);
            default: bg_rgb = 24'h000000;
        endcase
    end

    wire [10:0] xs = tl_q[`F_HIGH];
    wire [10:0] ys = tl_q[`F_LOW];
    wire [10:0] xe = br_q[`F_HIGH];
    wire [10:0] ye = br_q[`F_LOW];
    wire in_win = (hcnt_q >= xs) & (hcnt_q <= xe) & (vcnt_q >= ys) & (vcnt_q <= ye);
    wire ovl_on = oc_q[`F_OVL_EN] & in_win;
    wire [31:0] ow = fetch.ov_word;
    wire [23:0] ov_rgb = fmt666(ow[17:0]);
    wire [7:0] alpha = oc_q[`F_OVL_PIX] ? ow[31:24] : oc_q[`F_OVL_ALPHA];
    wire [23:0] mix = {blend8(alpha, ov_rgb[23:16], bg_rgb[23:16]),
                       blend8(alpha, ov_rgb[15:8], bg_rgb[15:8]),
                       blend8(alpha, ov_rgb[7:0], bg_rgb[7:0])};
    wire [23:0] ovl_rgb = color_key_en ? ov_rgb : mix;
    wire [23:0] pix = ovl_on ? ovl_rgb : bg_rgb;

    logic ls_q, fs_q, dv_q;
    logic [23:0] rgb_q;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ls_q <= 1'b0;
            fs_q <= 1'b0;
            dv_q <= 1'b0;
            rgb_q <= 24'h000000;
        end else if (ce && !running) begin
            ls_q <= 1'b0;
            fs_q <= 1'b0;
            dv_q <= 1'b0;
            rgb_q <= 24'h000000;
        end else if (tick) begin
            ls_q <= (hph_q == PH_SYNC) ^ pol_q[`F_LSYNC_INV];
            fs_q <= (vph_q == PH_SYNC) ^ pol_q[`F_FSYNC_INV];
            dv_q <= in_active ^ pol_q[`F_DV_INV];
            rgb_q <= take ? pix : 24'h000000;
        end
    end

    // data changes as the internal clock rises, so the panel samples mid-period
    assign panel.pixel_clock = running & (pclk_q ^ pol_q[`F_EDGE_SEL]);
    assign panel.line_sync = ls_q;
    assign panel.frame_sync = fs_q;
    assign panel.data_valid = dv_q;
    assign panel.rgb = rgb_q;

    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_sync_n);

    sequence s_line_wrap;
        tick && h_last && hph_q == PH_FRONT;
    endsequence

    sequence s_back_done;
        line_end && v_last && vph_q == PH_BACK;
    endsequence

    AST_RESERVED_DEPTH: assert property (
        take && depth[3] && !ovl_on |=> panel.rgb == 24'h000000)
        else $error("reserved depth produced pixel data");
    AST_STOP_NOW: assert property (
        ce && !running |=> !panel.data_valid && !panel.line_sync && !panel.frame_sync)
        else $error("outputs not stopped");
    // the clock gate is combinational, so a restart may show the clock one edge later
    AST_STOP_CLOCK: assert property (
        !running |-> !panel.pixel_clock)
        else $error("pixel clock runs while stopped");
    AST_FRAME_END_APPLY: assert property (
        ce && frame_end |=> run_q == $past(fe_pend_q))
        else $error("frame-end enable not applied at frame end");
    AST_FRAME_END_HOLD: assert property (
        ce && running && run_q && !frame_end |=> run_q && fe_read)
        else $error("frame-end enable dropped before frame end");
    AST_LINE_WRAP: assert property (
        s_line_wrap |=> hcnt_q == 11'h000 && hph_q == PH_SYNC)
        else $error("line did not wrap to sync");
    AST_BACK_TO_ACTIVE: assert property (
        s_back_done |=> vph_q == PH_ACTIVE && vcnt_q == 11'h000)
        else $error("back porch not followed by active lines");
    AST_DIV_TOGGLE: assert property (
        ce && running && div_wrap |=> pclk_q != $past(pclk_q))
        else $error("pixel clock did not toggle at divider wrap");
    AST_LINE_SYNC_POL: assert property (
        tick && running |=>
            panel.line_sync == ($past(hph_q == PH_SYNC) ^ $past(pol_q[`F_LSYNC_INV])))
        else $error("line sync level wrong");
    AST_OVERLAY_OFF: assert property (
        take && !oc_q[`F_OVL_EN] |=> panel.rgb == $past(bg_rgb))
        else $error("overlay shown while disabled");
    AST_KEY_BYPASS: assert property (
        take && ovl_on && color_key_en |=> panel.rgb == $past(ov_rgb))
        else $error("keyed overlay pixel was blended");
    AST_RESP_HOLD: assert property (
        bvalid_q && !axi_req.bready |=> bvalid_q ##0 $stable(bresp_q))
        else $error("write response withdrawn");
endmodule

/* verif/panel_model.sv */
// behavioural panel that counts the pixels it samples on each line
`timescale 1ns/1ps
module panel_model (
    input wire lcd_timing_pkg::panel_s panel,
    input wire logic sample_rise,
    input wire logic dv_high,
    output int line_pixels
);
    import lcd_timing_pkg::*;
    int cnt = 0;
    // samples on the edge the edge select bit names
    always @(panel.pixel_clock) begin
        if (panel.pixel_clock === sample_rise) begin
            if (panel.data_valid === dv_high) begin
                cnt++;
            end else if (cnt != 0) begin
                line_pixels = cnt;
                cnt = 0;
            end
        end
    end
endmodule

/* verif/testbench.sv */
// self-checking bench: registers, panel timing and enables
`timescale 1ns/1ps
`include "lcd_timing_map.svh"
module testbench;
    import lcd_timing_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    logic ce = 1;
    logic key_en = 0;
    logic rise = 0;
    logic dv_hi = 1;
    axi_req_s rq = '0;
    axi_rsp_s rs;
    fetch_s fe = '0;
    panel_s pn;
    int lpix;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    int n;
    logic [31:0] d;
    logic [33:0] expq[$];

    always #10 clk = ~clk;

    lcd_timing_overlay_control lcd_timing_overlay_control_inst (.clk(clk), .rst_n(rst_n),
        .ce(ce), .axi_req(rq), .axi_rsp(rs), .fetch(fe), .fetch_ready(),
        .color_key_en(key_en), .panel(pn));
    panel_model panel_model_inst (.panel(pn), .sample_rise(rise), .dv_high(dv_hi),
        .line_pixels(lpix));

    task automatic chk(input string w, input logic [33:0] e, input logic [33:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic complete_run;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
        expq.push_back({r, 32'h0});
        rq.awvalid <= 1'b1;
        rq.awaddr <= a;
        rq.wvalid <= 1'b1;
        rq.wdata <= v;
        rq.wstrb <= 4'hF;
        rq.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
        end while (!rs.bvalid);
        rq.bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [31:0] a, input logic [33:0] e);
        expq.push_back(e);
        rq.arvalid <= 1'b1;
        rq.araddr <= a;
        rq.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (rs.arready) rq.arvalid <= 1'b0;
        end while (!rs.rvalid);
        rq.rready <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic sig(input int s);
        return s == 0 ? pn.line_sync : s == 1 ? pn.frame_sync : pn.data_valid;
    endfunction

    // edges from s entering lvl until e shows stop
    task automatic meas(input int s, input logic l, input int e, input logic stop, input int x);
        n = 0;
        while (sig(s) === l) @(posedge clk);
        while (sig(s) !== l) @(posedge clk);
        while (sig(e) !== stop) begin
            @(posedge clk);
            n++;
        end
        chk("span", 34'(x), 34'(n));
    endtask

    task automatic pclk(input int k, input int e);
        n = 0;
        repeat (k) begin
            @(posedge clk);
            n += int'(pn.pixel_clock);
        end
        chk("pixel clock highs", 34'(e), 34'(n));
    endtask

    // v set means every sync and valid output is inverted
    // the back porch span must start in an active line: it follows the first one
    task automatic sweep(input logic v);
        meas(0, ~v, 0, v, 4);
        meas(1, ~v, 1, v, 20);
        meas(1, v, 1, ~v, 100);
        meas(1, v, 2, ~v, 50);
        meas(0, v, 2, ~v, 6);
        chk("pixel", 34'h0, {10'h0, pn.rgb});
        meas(2, v, 0, ~v, 2);
        meas(2, ~v, 2, v, 8);
        chk("panel pixels", 34'h4, 34'(lpix));
    endtask

    always @(posedge clk) begin
        fe.bg_word <= $urandom;
        fe.ov_word <= $urandom;
        key_en <= 1'($urandom);
        if (rs.rvalid && rq.rready)
            chk("read", expq.pop_front(), {rs.rresp, rs.rdata});
        if (rs.bvalid && rq.bready)
            chk("write response", expq.pop_front(), {rs.bresp, 32'h0});
        cyc++;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end

    // the palette is only touched while stopped, never in active lines
    initial begin
        void'($urandom(32'h9928114F));
        fe.valid <= 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rd(`ADDR_MAIN_CTRL + 32'(4 * i), 34'h0);
        end
        d = $urandom;
        wr(32'h4A000400, d, `RESP_OKAY);
        rd(32'h4A000400, {`RESP_OKAY, d});
        for (int i = 2; i < 8; i++) begin
            d = $urandom;
            wr(`ADDR_MAIN_CTRL + 32'(4 * i), d, `RESP_OKAY);
            d = d & (i < 4 ? `MASK_TIM : i == 5 ? `MASK_OVL_CTRL : `MASK_SIZE);
            rd(`ADDR_MAIN_CTRL + 32'(4 * i), {`RESP_OKAY, d});
        end
        wr(32'h4A000100, $urandom, `RESP_SLVERR);
        rd(32'h4A000100, {`RESP_SLVERR, 32'h0});
        wr(`ADDR_VERT_TIM, 32'h00010000, `RESP_OKAY);
        wr(`ADDR_HORIZ_TIM, 32'h00020001, `RESP_OKAY);
        wr(`ADDR_PANEL_SIZE, 32'h00000803, `RESP_OKAY);
        wr(`ADDR_OVL_CTRL, 32'h00000000, `RESP_OKAY);
        // divided by two, reserved depth so the background is black
        wr(`ADDR_MAIN_CTRL, 32'h00081022, `RESP_OKAY);
        sweep(1'b0);
        wr(`ADDR_STAT_POL, 32'h000000E8, `RESP_OKAY);
        rise <= 1'b1;
        dv_hi <= 1'b0;
        sweep(1'b1);
        wr(`ADDR_MAIN_CTRL, 32'h00081020, `RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("stopped", 34'h0, {pn.line_sync, pn.frame_sync, pn.data_valid});
        pclk(20, 0);
        wr(`ADDR_MAIN_CTRL, 32'h00081021, `RESP_OKAY);
        wr(`ADDR_MAIN_CTRL, 32'h00081020, `RESP_OKAY);
        rd(`ADDR_MAIN_CTRL, {2'h0, 32'h00081021});
        pclk(20, 10);
        // x start 0 is word aligned; the window stays inside the 4 by 2 panel
        wr(`ADDR_OVL_TL, 32'h00000000, `RESP_OKAY);
        wr(`ADDR_OVL_BR, 32'h00001801, `RESP_OKAY);
        wr(`ADDR_OVL_CTRL, 32'h000002FF, `RESP_OKAY);
        ce <= 1'b0;
        @(posedge clk);
        chk("frozen readies", 34'h0, {31'h0, rs.awready, rs.wready, rs.arready});
        ce <= 1'b1;
        repeat (200) @(posedge clk);
        pclk(20, 0);
        rd(`ADDR_MAIN_CTRL, {2'h0, 32'h00081020});
        complete_run();
    end
endmodule
